// ===== evif_regs.sv
// Event-unit interrupt flag, mask and vector registers.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
module evif_regs (
  input  wire logic                           sys_clk_i,
  input  wire logic                           resetn_i,
  // Register port
  input  wire logic [evif_pkg::ADDR_W-1:0]    addr_i,
  input  wire logic [evif_pkg::DATA_W-1:0]    wr_data_i,
  input  wire logic                           wr_i,
  input  wire logic                           rd_i,
  output logic      [evif_pkg::DATA_W-1:0]    rd_data_o,
  // Event pulses from the timers, compare units and fault input
  input  wire logic [evif_pkg::GRPA_W-1:0]    evt_a_i,
  input  wire logic [evif_pkg::GRPB_W-1:0]    evt_b_i,
  // Interrupt lines
  output logic                                core_irq_line_two_o,
  output logic                                core_irq_line_three_o,
  output logic                                irq_o
);
  import evif_pkg::*;

  evif_grp_if #(.W(GRPA_W)) grp_a ();
  evif_grp_if #(.W(GRPB_W)) grp_b ();

  logic [GRPA_W-1:0] mask_a_r;
  logic [GRPA_W-1:0] mask_a_nxt;
  logic [GRPB_W-1:0] mask_b_r;
  logic [GRPB_W-1:0] mask_b_nxt;
  logic [DATA_W-1:0] rd_data_r;
  logic [DATA_W-1:0] rd_data_nxt;
  logic              irq_a_r;
  logic              irq_a_nxt;
  logic              irq_b_r;
  logic              irq_b_nxt;
  logic              irq_r;
  logic              irq_nxt;

  logic [GRPA_W-1:0] pend_a;
  logic [GRPB_W-1:0] pend_b;
  logic [GRPA_W-1:0] top_a;
  logic [GRPB_W-1:0] top_b;
  logic [4:0]        idx_a;
  logic [4:0]        idx_b;
  logic              any_a;
  logic              any_b;
  logic [VEC_W-1:0]  vec_a;
  logic [VEC_W-1:0]  vec_b;

  // Address match for one strobe
  function automatic logic hit(input logic strobe, input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    return strobe && (a == ofs);
  endfunction

  // Vector value, zero when nothing is pending so stray requests are recognisable
  function automatic logic [VEC_W-1:0] vec_of(input logic any, input logic [4:0] idx,
                                               input logic [VEC_W-1:0] base);
    return any ? VEC_W'(base + VEC_W'(idx)) : VEC_NONE;
  endfunction

  // Flags that are both set and enabled
  assign pend_a = grp_a.flags & mask_a_r;
  assign pend_b = grp_b.flags & mask_b_r;

  evif_prio_enc #(.W(GRPA_W)) u_prio_a (
    .pend_i   (pend_a),
    .onehot_o (top_a),
    .index_o  (idx_a),
    .any_o    (any_a)
  );

  evif_prio_enc #(.W(GRPB_W)) u_prio_b (
    .pend_i   (pend_b),
    .onehot_o (top_b),
    .index_o  (idx_b),
    .any_o    (any_b)
  );

  assign vec_a = vec_of(any_a, idx_a, VEC_BASE_A);
  assign vec_b = vec_of(any_b, idx_b, VEC_BASE_B);

  // Event routing; bit positions follow the field constants
  always_comb begin
    grp_a.evt = '0;
    grp_b.evt = '0;
    grp_a.evt[BIT_POWER_FAULT]  = evt_a_i[BIT_POWER_FAULT];
    grp_a.evt[BIT_FULL_CMP1]    = evt_a_i[BIT_FULL_CMP1];
    grp_a.evt[BIT_FULL_CMP2]    = evt_a_i[BIT_FULL_CMP2];
    grp_a.evt[BIT_FULL_CMP3]    = evt_a_i[BIT_FULL_CMP3];
    grp_a.evt[BIT_SIMPLE_CMP1]  = evt_a_i[BIT_SIMPLE_CMP1];
    grp_a.evt[BIT_SIMPLE_CMP2]  = evt_a_i[BIT_SIMPLE_CMP2];
    grp_a.evt[BIT_SIMPLE_CMP3]  = evt_a_i[BIT_SIMPLE_CMP3];
    grp_a.evt[BIT_T1_PERIOD]    = evt_a_i[BIT_T1_PERIOD];
    grp_a.evt[BIT_T1_COMPARE]   = evt_a_i[BIT_T1_COMPARE];
    grp_a.evt[BIT_T1_UNDERFLOW] = evt_a_i[BIT_T1_UNDERFLOW];
    grp_a.evt[BIT_T1_OVERFLOW]  = evt_a_i[BIT_T1_OVERFLOW];
    // timer 2 low nibble, timer 3 high nibble
    grp_b.evt[BIT_T2_PERIOD]    = evt_b_i[BIT_T2_PERIOD];
    grp_b.evt[BIT_T2_COMPARE]   = evt_b_i[BIT_T2_COMPARE];
    grp_b.evt[BIT_T2_UNDERFLOW] = evt_b_i[BIT_T2_UNDERFLOW];
    grp_b.evt[BIT_T2_OVERFLOW]  = evt_b_i[BIT_T2_OVERFLOW];
    grp_b.evt[BIT_T3_PERIOD]    = evt_b_i[BIT_T3_PERIOD];
    grp_b.evt[BIT_T3_COMPARE]   = evt_b_i[BIT_T3_COMPARE];
    grp_b.evt[BIT_T3_UNDERFLOW] = evt_b_i[BIT_T3_UNDERFLOW];
    grp_b.evt[BIT_T3_OVERFLOW]  = evt_b_i[BIT_T3_OVERFLOW];
  end

  // Clear requests from flag writes, clear-register writes and vector reads
  always_comb begin
    grp_a.clr = '0;
    grp_b.clr = '0;
    if (hit(wr_i, addr_i, OFS_FLAGS_A) || hit(wr_i, addr_i, OFS_CLR_A)) begin
      grp_a.clr = wr_data_i[GRPA_W-1:0];
    end
    if (hit(wr_i, addr_i, OFS_FLAGS_B) || hit(wr_i, addr_i, OFS_CLR_B)) begin
      grp_b.clr = wr_data_i[GRPB_W-1:0];
    end
    if (hit(rd_i, addr_i, OFS_VEC_A)) begin
      grp_a.clr = grp_a.clr | top_a;
    end
    if (hit(rd_i, addr_i, OFS_VEC_B)) begin
      grp_b.clr = grp_b.clr | top_b;
    end
  end

  evif_flag_grp #(.W(GRPA_W)) u_grp_a (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .grp       (grp_a.grp)
  );

  evif_flag_grp #(.W(GRPB_W)) u_grp_b (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .grp       (grp_b.grp)
  );

  // Mask registers; reserved bits are simply not stored
  always_comb begin
    mask_a_nxt = mask_a_r;
    mask_b_nxt = mask_b_r;
    if (hit(wr_i, addr_i, OFS_MASK_A)) begin
      mask_a_nxt = wr_data_i[GRPA_W-1:0];
    end
    if (hit(wr_i, addr_i, OFS_MASK_B)) begin
      mask_b_nxt = wr_data_i[GRPB_W-1:0];
    end
  end

  // Read mux; clear registers are write-only and read 0, like unmapped space
  always_comb begin
    rd_data_nxt = '0;
    if (rd_i) begin
      unique case (addr_i)
        OFS_FLAGS_A: rd_data_nxt = DATA_W'(grp_a.flags);
        OFS_FLAGS_B: rd_data_nxt = DATA_W'(grp_b.flags);
        OFS_MASK_A:  rd_data_nxt = DATA_W'(mask_a_r);
        OFS_MASK_B:  rd_data_nxt = DATA_W'(mask_b_r);
        OFS_VEC_A:   rd_data_nxt = DATA_W'(vec_a);
        OFS_VEC_B:   rd_data_nxt = DATA_W'(vec_b);
        default:     rd_data_nxt = '0;
      endcase
    end
  end

  // Interrupt levels; registered, so one cycle behind the flags
  always_comb begin
    irq_a_nxt = any_a;
    irq_b_nxt = any_b;
    irq_nxt   = any_a | any_b;
  end

  // Register stage
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      mask_a_r  <= RST_MASK[GRPA_W-1:0];
      mask_b_r  <= RST_MASK[GRPB_W-1:0];
      rd_data_r <= '0;
      irq_a_r   <= 1'b0;
      irq_b_r   <= 1'b0;
      irq_r     <= 1'b0;
    end else begin
      mask_a_r  <= mask_a_nxt;
      mask_b_r  <= mask_b_nxt;
      rd_data_r <= rd_data_nxt;
      irq_a_r   <= irq_a_nxt;
      irq_b_r   <= irq_b_nxt;
      irq_r     <= irq_nxt;
    end
  end

  assign rd_data_o             = rd_data_r;
  assign core_irq_line_two_o   = irq_a_r;
  assign core_irq_line_three_o = irq_b_r;
  assign irq_o                 = irq_r;
endmodule // evif_regs

// ===== evif_pkg.sv
// Constants of the event-unit interrupt flag registers.
//
// Contract
// - Group A bits 15 to 11 read 0 and ignore writes.
// - All flag bits are readable and writable, zero after reset.
// - A read returns 1 for a pending flag, 0 otherwise.
// - Writing 1 clears a flag; writing 0 leaves it alone.
// - Group A bit 10 is the timer 1 overflow flag.
// - Group A bit 9 is the timer 1 underflow flag.
// - Group A bit 8 is the timer 1 compare flag.
// - Group A bit 7 is the timer 1 period flag.
// - Group A bits 6..4 are simple compare 3, 2, 1 flags.
// - Group A bits 3..1 are full compare 3, 2, 1 flags.
// - Group A bit 0 is the power fault flag.
// - Group B: bits 15..8 reserved, timer 3 flags 7..4, timer 2 flags 3..0.
// - An event sets its matching flag bit.
// - Set and enabled flags raise core line two (A) or three (B).
// - Reading a group vector clears the flag it returned.
package evif_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned GRPA_W = 11;
  localparam int unsigned GRPB_W = 8;
  localparam int unsigned VEC_W  = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_MASK_A  = 16'h742C;
  localparam logic [ADDR_W-1:0] OFS_MASK_B  = 16'h742D;
  localparam logic [ADDR_W-1:0] OFS_FLAGS_A = 16'h742F;
  localparam logic [ADDR_W-1:0] OFS_FLAGS_B = 16'h7430;
  localparam logic [ADDR_W-1:0] OFS_VEC_A   = 16'h7432;
  localparam logic [ADDR_W-1:0] OFS_VEC_B   = 16'h7433;
  localparam logic [ADDR_W-1:0] OFS_CLR_A   = 16'h7434;
  localparam logic [ADDR_W-1:0] OFS_CLR_B   = 16'h7435;

  // Group A field positions
  localparam int unsigned BIT_POWER_FAULT    = 0;
  localparam int unsigned BIT_FULL_CMP1      = 1;
  localparam int unsigned BIT_FULL_CMP2      = 2;
  localparam int unsigned BIT_FULL_CMP3      = 3;
  localparam int unsigned BIT_SIMPLE_CMP1    = 4;
  localparam int unsigned BIT_SIMPLE_CMP2    = 5;
  localparam int unsigned BIT_SIMPLE_CMP3    = 6;
  localparam int unsigned BIT_T1_PERIOD      = 7;
  localparam int unsigned BIT_T1_COMPARE     = 8;
  localparam int unsigned BIT_T1_UNDERFLOW   = 9;
  localparam int unsigned BIT_T1_OVERFLOW    = 10;
  // Group B field positions
  localparam int unsigned BIT_T2_PERIOD      = 0;
  localparam int unsigned BIT_T2_COMPARE     = 1;
  localparam int unsigned BIT_T2_UNDERFLOW   = 2;
  localparam int unsigned BIT_T2_OVERFLOW    = 3;
  localparam int unsigned BIT_T3_PERIOD      = 4;
  localparam int unsigned BIT_T3_COMPARE     = 5;
  localparam int unsigned BIT_T3_UNDERFLOW   = 6;
  localparam int unsigned BIT_T3_OVERFLOW    = 7;

  // Reset values and vector bases
  localparam logic [DATA_W-1:0] RST_FLAGS  = 16'h0000;
  localparam logic [DATA_W-1:0] RST_MASK   = 16'h0000;
  localparam logic [VEC_W-1:0]  VEC_BASE_A = 8'h20;
  localparam logic [VEC_W-1:0]  VEC_BASE_B = 8'h2B;
  localparam logic [VEC_W-1:0]  VEC_NONE   = 8'h00;
endpackage : evif_pkg

// ===== evif_grp_if.sv
// Interface between the register front end and one flag group.
`timescale 1ns/10ps
interface evif_grp_if #(
  parameter int unsigned W = 8
);
  logic [W-1:0] evt;    // Event pulses
  logic [W-1:0] clr;    // Clear requests, one per bit
  logic [W-1:0] flags;  // Current flag state

  modport ctrl (output evt, output clr, input flags);
  modport grp  (input evt, input clr, output flags);
endinterface : evif_grp_if

// ===== evif_flag_grp.sv
// One group of sticky event flags with write-one-to-clear.
`timescale 1ns/10ps
module evif_flag_grp #(
  parameter int unsigned W = 8
) (
  input  wire logic    sys_clk_i,
  input  wire logic    resetn_i,
  evif_grp_if.grp      grp
);
  import evif_pkg::*;

  logic [W-1:0] flags_r;
  logic [W-1:0] flags_nxt;

  // Next flag state
  always_comb begin
    flags_nxt = (flags_r & ~grp.clr) | grp.evt;
  end

  // Flag storage
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      flags_r <= RST_FLAGS[W-1:0];
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign grp.flags = flags_r;
endmodule // evif_flag_grp

// ===== evif_prio_enc.sv
// Picks the lowest-numbered pending bit, which has top priority.
`timescale 1ns/10ps
module evif_prio_enc #(
  parameter int unsigned W = 8
) (
  input  wire logic [W-1:0] pend_i,
  output logic      [W-1:0] onehot_o,
  output logic      [4:0]   index_o,
  output logic              any_o
);
  // Scan downward so the lowest index is taken last and wins
  always_comb begin
    onehot_o = '0;
    index_o  = '0;
    any_o    = 1'b0;
    for (int i = W - 1; i >= 0; i--) begin
      if (pend_i[i]) begin
        onehot_o = '0;
        onehot_o[i] = 1'b1;
        index_o  = 5'(i);
        any_o    = 1'b1;
      end
    end
  end
endmodule // evif_prio_enc

// ===== evif_regs_properties.sv
// Port-level checks for the event flag register block.
`timescale 1ns/10ps
module evif_regs_properties (
  input wire logic                        sys_clk_i,
  input wire logic                        resetn_i,
  input wire logic [evif_pkg::ADDR_W-1:0] addr_i,
  input wire logic [evif_pkg::DATA_W-1:0] wr_data_i,
  input wire logic                        wr_i,
  input wire logic                        rd_i,
  input wire logic [evif_pkg::DATA_W-1:0] rd_data_o,
  input wire logic [evif_pkg::GRPA_W-1:0] evt_a_i,
  input wire logic [evif_pkg::GRPB_W-1:0] evt_b_i,
  input wire logic                        core_irq_line_two_o,
  input wire logic                        core_irq_line_three_o,
  input wire logic                        irq_o
);
  import evif_pkg::*;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  logic rda;
  logic rdb;
  // Flag register read decode
  assign rda = rd_i && addr_i == OFS_FLAGS_A;
  assign rdb = rd_i && addr_i == OFS_FLAGS_B;
  AST_RD_IDLE: assert property (!$past(rd_i) |-> rd_data_o == 16'h0000)
    else $error("read data outside read slot");
  AST_A_RSVD: assert property (rda |=> rd_data_o[15:11] == 5'h00)
    else $error("group A reserved bits not zero");
  AST_B_RSVD: assert property (rdb |=> rd_data_o[15:8] == 8'h00)
    else $error("group B reserved bits not zero");
  // No strobe in between, so nothing could clear the flag
  AST_A_SET: assert property (rda && !$past(wr_i || rd_i) |=> &(rd_data_o[10:0] | ~$past(evt_a_i, 3)))
    else $error("group A event lost");
  AST_B_SET: assert property (rdb && !$past(wr_i || rd_i) |=> &(rd_data_o[7:0] | ~$past(evt_b_i, 3)))
    else $error("group B event lost");
  AST_A_CLR: assert property (wr_i && addr_i == OFS_FLAGS_A ##2 rda |=>
    (rd_data_o[10:0] & $past(wr_data_i[10:0], 3) & ~$past(evt_a_i, 3) & ~$past(evt_a_i, 2)) == 11'h000)
    else $error("group A flag not cleared");
  AST_IRQ_OR: assert property (irq_o == (core_irq_line_two_o || core_irq_line_three_o))
    else $error("combined line differs from group lines");
  AST_IRQ2_CAUSE: assert property ($rose(core_irq_line_two_o) |-> $past(|evt_a_i, 2) || $past(wr_i, 2))
    else $error("line two rose without cause");
  AST_IRQ3_CAUSE: assert property ($rose(core_irq_line_three_o) |-> $past(|evt_b_i, 2) || $past(wr_i, 2))
    else $error("line three rose without cause");
  AST_RESET: assert property (disable iff (1'b0) !resetn_i |=> rd_data_o == 16'h0000 && !irq_o)
    else $error("outputs not cleared by reset");
  cover property (rd_i && addr_i == OFS_VEC_A);
  cover property ($rose(core_irq_line_three_o));
  cover property (wr_i && addr_i == OFS_FLAGS_A && |evt_a_i);
endmodule // evif_regs_properties

// ===== evif_core_model.sv
// Core-side model that counts requests on each interrupt line.
`timescale 1ns/10ps
module evif_core_model (
  input  wire logic       sys_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       line_two_i,
  input  wire logic       line_three_i,
  output logic      [7:0] taken_two_o,
  output logic      [7:0] taken_three_o
);
  logic two_q;
  logic three_q;
  // Lines are levels; a request counts once, on its rising edge
  always @(posedge sys_clk_i) begin
    two_q <= resetn_i && line_two_i;
    three_q <= resetn_i && line_three_i;
    taken_two_o <= !resetn_i ? 8'h00 : taken_two_o + {7'h00, line_two_i && !two_q};
    taken_three_o <= !resetn_i ? 8'h00 : taken_three_o + {7'h00, line_three_i && !three_q};
  end
endmodule // evif_core_model

// ===== event_interrupt_flag_regs_test.sv
// Self-checking bench for the event flag register block.
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %0t: got %h, expected %h", $time, g, e); end end
module event_interrupt_flag_regs_test;
  import evif_pkg::*;
  typedef struct {logic [10:0] ea; logic [7:0] eb; logic [15:0] ca, cb, xa, xb;} evif_row_t;
  logic              sys_clk_i, resetn_i, wr_i, rd_i;
  logic              core_irq_line_two_o, core_irq_line_three_o, irq_o;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wr_data_i, rd_data_o;
  logic [GRPA_W-1:0] evt_a_i;
  logic [GRPB_W-1:0] evt_b_i;
  logic [7:0]        taken_two, taken_three;
  int                num_errors = 0;
  int                n_compared = 0;
  logic [15:0]       ofs [8] = '{OFS_FLAGS_A, OFS_FLAGS_B, OFS_MASK_A, OFS_MASK_B, OFS_VEC_A, OFS_VEC_B,
                                 OFS_CLR_A, 16'h7431};
  // Events, clears of A then B, expected flags A and B
  evif_row_t rows [6] = '{
    '{11'h400, 8'h00, 16'h0000, 16'h0000, 16'h0400, 16'h0000},
    '{11'h380, 8'h00, 16'h0100, 16'h0000, 16'h0280, 16'h0000},
    '{11'h070, 8'h00, 16'hF810, 16'h0000, 16'h0060, 16'h0000},
    '{11'h00F, 8'h00, 16'h0005, 16'h0000, 16'h000A, 16'h0000},
    '{11'h000, 8'hF0, 16'h0000, 16'hFF80, 16'h0000, 16'h0070},
    '{11'h7FF, 8'h0F, 16'h0000, 16'h0003, 16'h07FF, 16'h000C}};

  evif_regs evif_regs_i (.sys_clk_i, .resetn_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o,
    .evt_a_i, .evt_b_i, .core_irq_line_two_o, .core_irq_line_three_o, .irq_o);
  evif_core_model evif_core_model_i (.sys_clk_i, .resetn_i, .line_two_i(core_irq_line_two_o),
    .line_three_i(core_irq_line_three_o), .taken_two_o(taken_two), .taken_three_o(taken_three));

  // Bus tasks lead with an edge, so strobes never toggle twice in a step
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wr_data_i <= d;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] x);
    @(posedge sys_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    `CHK(rd_data_o, x)
  endtask
  task automatic ev(input logic [10:0] a, input logic [7:0] b);
    @(posedge sys_clk_i);
    evt_a_i <= a;
    evt_b_i <= b;
    @(posedge sys_clk_i);
    evt_a_i <= '0;
    evt_b_i <= '0;
  endtask
  task automatic print_verdict;
    $display("Mismatches %0d, comparisons %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // 50 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  // Watchdog well beyond the 160 or so cycles the run needs
  initial begin
    repeat (3000) @(posedge sys_clk_i);
    num_errors++;
    print_verdict();
  end
  // Main sequence
  initial begin
    {resetn_i, wr_i, rd_i, addr_i, wr_data_i, evt_a_i, evt_b_i} = '0;
    repeat (10) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    wr(16'h7431, 16'hFFFF);
    foreach (ofs[i]) rd(ofs[i], 16'h0000);
    foreach (rows[i]) begin
      ev(rows[i].ea, rows[i].eb);
      wr(OFS_FLAGS_B, rows[i].cb);
      wr(OFS_FLAGS_A, rows[i].ca);
      rd(OFS_FLAGS_A, rows[i].xa);
      rd(OFS_FLAGS_B, rows[i].xb);
      wr(OFS_FLAGS_A, 16'hFFFF);
      wr(OFS_FLAGS_B, 16'hFFFF);
    end
    // Event and clear land in one cycle
    @(posedge sys_clk_i);
    evt_a_i <= 11'h001;
    wr_i <= 1'b1;
    addr_i <= OFS_FLAGS_A;
    wr_data_i <= 16'hFFFF;
    @(posedge sys_clk_i);
    evt_a_i <= '0;
    wr_i <= 1'b0;
    rd(OFS_FLAGS_A, 16'h0001);
    wr(OFS_FLAGS_A, 16'h0001);
    // Group A request, vectors in priority order
    wr(OFS_MASK_A, 16'hFFFF);
    ev(11'h00C, 8'h00);
    @(posedge sys_clk_i);
    #1;
    `CHK({core_irq_line_two_o, irq_o}, 2'b11)
    rd(OFS_VEC_A, 16'h0022);
    rd(OFS_VEC_A, 16'h0023);
    rd(OFS_VEC_A, 16'h0000);
    rd(OFS_FLAGS_A, 16'h0000);
    `CHK({core_irq_line_two_o, irq_o}, 2'b00)
    // Group B request, partly masked, then the clear register
    wr(OFS_MASK_B, 16'h0004);
    ev(11'h000, 8'h06);
    rd(OFS_VEC_B, 16'h002D);
    // Line still high here: it falls one cycle after the vector read
    `CHK({core_irq_line_three_o, irq_o}, 2'b11)
    rd(OFS_FLAGS_B, 16'h0002);
    wr(OFS_CLR_B, 16'h0002);
    rd(OFS_FLAGS_B, 16'h0000);
    // Masked events still set flags; clear register A drops only its ones
    wr(OFS_MASK_A, 16'h0000);
    ev(11'h401, 8'h80);
    rd(OFS_FLAGS_B, 16'h0080);
    `CHK({core_irq_line_two_o, core_irq_line_three_o}, 2'b00)
    wr(OFS_CLR_A, 16'h0001);
    rd(OFS_FLAGS_A, 16'h0400);
    `CHK({taken_two, taken_three}, 16'h0101)
    // Reset in mid-run drops pending flags
    @(posedge sys_clk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    rd(OFS_FLAGS_A, 16'h0000);
    rd(OFS_FLAGS_B, 16'h0000);
    print_verdict();
  end
endmodule // event_interrupt_flag_regs_test

bind evif_regs evif_regs_properties evif_regs_properties_i (.sys_clk_i, .resetn_i, .addr_i, .wr_data_i,
  .wr_i, .rd_i, .rd_data_o, .evt_a_i, .evt_b_i, .core_irq_line_two_o, .core_irq_line_three_o, .irq_o);
